// ==== rtl/obt_defines.svh ====
// Register offsets, field positions and reset values of the transceiver
`ifndef OBT_DEFINES_SVH
`define OBT_DEFINES_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define OBT_CTRL_OFS 12'h000
`define OBT_STATUS_OFS 12'h004
`define OBT_LOG_OFS 12'h008

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define OBT_CTRL_LOG_EN_BIT 0
`define OBT_ST_AB_LSB 0
`define OBT_ST_BA_LSB 8
`define OBT_ST_OE_N_BIT 16
`define OBT_ST_DIR_BIT 17
`define OBT_ST_EMPTY_BIT 18
`define OBT_ST_FULL_BIT 19
`define OBT_ST_OVF_BIT 20

// ------------------------------------------------------------
// Reset values and sizes
// ------------------------------------------------------------
`define OBT_CTRL_RST 1'h0
`define OBT_STORE_RST 8'h00
`define OBT_LOG_DEPTH 4

`endif

// ==== rtl/obt_pkg.sv ====
// Types shared by the octal registered bus transceiver
package obt_pkg;

   // ------------------------------------------------------------
   // Pin-level control group
   // ------------------------------------------------------------
   typedef struct packed {
      logic oe_n;       // Output enable, active low
      logic dir;        // High drives B, low drives A
      logic a_to_b_source_select;
      logic b_to_a_source_select;
   } obt_ctrl_t;

   // ------------------------------------------------------------
   // Stored register pair
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] a_to_b;  // Last A-side capture
      logic [7:0] b_to_a;  // Last B-side capture
   } obt_store_t;

endpackage

// ==== rtl/obt_transceiver.sv ====
// Octal registered bus transceiver with APB status and capture log FIFO
//
// Contract
// - Capture clock rise loads its bus register
// - Output enable high tristates both sides
// - Captures continue while outputs are disabled
// - Enabled, direction high: drive B side
// - Enabled, direction low: drive A side
// - B shows live A when select low
// - B shows A-to-B register when select high
// - A shows live B when select low
// - A shows B-to-A register when select high
// - New stored value appears on driven side
// - Registers load every edge, in any mode
// - Registers hold between capture edges
// - Input-side data storable in either/both registers
`timescale 1ns/1ps
`include "obt_defines.svh"

// ------------------------------------------------------------
// Small synchronous FIFO
// ------------------------------------------------------------
module obt_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Fill side
   input wire logic i_valid,
   output logic o_ready,
   input wire logic [WIDTH-1:0] i_data,
   // Drain side
   output logic o_valid,
   input wire logic i_ready,
   output logic [WIDTH-1:0] o_data
);
   localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

   logic [WIDTH-1:0] mem_q [DEPTH];  // Storage words
   logic [AW-1:0] wr_q, wr_d;        // Write pointer
   logic [AW-1:0] rd_q, rd_d;        // Read pointer
   logic [AW:0] cnt_q, cnt_d;        // Fill level
   logic push, pop;

   // Flags straight from the fill level
   assign o_ready = (cnt_q != (AW+1)'(DEPTH));
   assign o_valid = (cnt_q != '0);
   assign o_data = mem_q[rd_q];
   assign push = i_valid && o_ready;
   assign pop = o_valid && i_ready;

   // ------------------------------------------------------------
   // Pointer and level update
   // ------------------------------------------------------------
   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      // Wrap explicitly so depths other than a power of two work
      if (push) begin
         wr_d = (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + AW'(1);
      end
      if (pop) begin
         rd_d = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + AW'(1);
      end
      if (push && !pop) begin
         cnt_d = cnt_q + (AW+1)'(1);
      end else if (pop && !push) begin
         cnt_d = cnt_q - (AW+1)'(1);
      end
   end

   // Register pointers; storage needs no reset
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
      if (push) begin
         mem_q[wr_q] <= i_data;
      end
   end
endmodule

// ------------------------------------------------------------
// Transceiver top
// ------------------------------------------------------------
module obt_transceiver #(
   parameter int LOG_DEPTH = `OBT_LOG_DEPTH
) (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Control pins
   input wire logic i_oe_n,
   input wire logic i_dir,
   input wire logic i_a_to_b_capture_clock,
   input wire logic i_b_to_a_capture_clock,
   input wire logic i_a_to_b_source_select,
   input wire logic i_b_to_a_source_select,
   // A side lines
   input wire logic [7:0] i_a_side_lines,
   output logic [7:0] o_a_side_lines,
   output logic o_a_side_oe,
   // B side lines
   input wire logic [7:0] i_b_side_lines,
   output logic [7:0] o_b_side_lines,
   output logic o_b_side_oe,
   // Log back-pressure
   output logic o_log_ready,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr
);
   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   obt_pkg::obt_ctrl_t ctrl;           // Pin control bundle
   obt_pkg::obt_store_t store_q;       // Stored register pair
   obt_pkg::obt_store_t store_d;
   logic ab_prev_q, ab_prev_d;         // Previous capture clock levels
   logic ba_prev_q, ba_prev_d;
   logic ab_rise, ba_rise;             // Capture clock rising edges
   logic [7:0] a_out_q, a_out_d;       // A side drive value
   logic [7:0] b_out_q, b_out_d;       // B side drive value
   logic a_oe_q, a_oe_d;               // A side driving
   logic b_oe_q, b_oe_d;               // B side driving
   logic log_en_q, log_en_d;           // Capture logging enable
   logic ovf_q, ovf_d;                 // Sticky log overflow
   logic lrdy_q;                       // Registered log ready
   logic [31:0] prdata_q, prdata_d;    // APB read data
   logic pready_q, pready_d;
   logic pslverr_q, pslverr_d;
   logic setup, access_done;           // APB phases
   logic log_push, log_rdy;            // FIFO fill side
   logic log_valid, log_pop;           // FIFO drain side
   logic [7:0] log_data;

   assign ctrl = '{oe_n: i_oe_n, dir: i_dir,
                   a_to_b_source_select: i_a_to_b_source_select,
                   b_to_a_source_select: i_b_to_a_source_select};

   // Capture clocks are sampled by the system clock
   assign ab_rise = i_a_to_b_capture_clock && !ab_prev_q;
   assign ba_rise = i_b_to_a_capture_clock && !ba_prev_q;

   // ------------------------------------------------------------
   // Capture registers and bus drivers
   // ------------------------------------------------------------
   always_comb begin
      ab_prev_d = i_a_to_b_capture_clock;
      ba_prev_d = i_b_to_a_capture_clock;
      // Hold unless the matching clock rises
      store_d = store_q;
      // Each register loads its bus, whatever the mode or driver
      if (ab_rise) begin
         store_d.a_to_b = i_a_side_lines;
      end
      if (ba_rise) begin
         store_d.b_to_a = i_b_side_lines;
      end
      // Drivers follow enable and direction
      b_oe_d = !ctrl.oe_n && ctrl.dir;
      a_oe_d = !ctrl.oe_n && !ctrl.dir;
      // Next stored value used so a new capture shows at once
      if (ctrl.a_to_b_source_select) begin
         b_out_d = store_d.a_to_b;
      end else begin
         b_out_d = i_a_side_lines;
      end
      if (ctrl.b_to_a_source_select) begin
         a_out_d = store_d.b_to_a;
      end else begin
         a_out_d = i_b_side_lines;
      end
   end

   // Register capture and drive state
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         store_q <= {`OBT_STORE_RST, `OBT_STORE_RST};
         ab_prev_q <= 1'b0;
         ba_prev_q <= 1'b0;
         a_out_q <= 8'h00;
         b_out_q <= 8'h00;
         a_oe_q <= 1'b0;
         b_oe_q <= 1'b0;
      end else begin
         store_q <= store_d;
         ab_prev_q <= ab_prev_d;
         ba_prev_q <= ba_prev_d;
         a_out_q <= a_out_d;
         b_out_q <= b_out_d;
         a_oe_q <= a_oe_d;
         b_oe_q <= b_oe_d;
      end
   end

   // ------------------------------------------------------------
   // Capture log FIFO
   // ------------------------------------------------------------
   // Logs A-to-B captures; a full log never blocks the capture itself
   assign log_push = log_en_q && ab_rise;

   obt_fifo #(
      .WIDTH(8),
      .DEPTH(LOG_DEPTH)
   ) u_log (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_valid(log_push),
      .o_ready(log_rdy),
      .i_data(i_a_side_lines),
      .o_valid(log_valid),
      .i_ready(log_pop),
      .o_data(log_data)
   );

   // ------------------------------------------------------------
   // APB slave, one wait-free access phase
   // ------------------------------------------------------------
   assign setup = i_psel && !i_penable;
   assign access_done = i_psel && i_penable && pready_q;
   // Reading the log pops it at the completing edge
   assign log_pop = access_done && !i_pwrite &&
                    (i_paddr == `OBT_LOG_OFS);

   always_comb begin
      log_en_d = log_en_q;
      ovf_d = ovf_q;
      prdata_d = prdata_q;
      pready_d = setup;
      pslverr_d = 1'b0;
      // Register writes take effect at the completing edge
      if (access_done && i_pwrite) begin
         if (i_paddr == `OBT_CTRL_OFS) begin
            log_en_d = i_pwdata[`OBT_CTRL_LOG_EN_BIT];
         end else if (i_paddr == `OBT_STATUS_OFS &&
                      i_pwdata[`OBT_ST_OVF_BIT]) begin
            ovf_d = 1'b0;
         end
      end
      // Lost log entry; set wins over a same-cycle clear
      if (log_push && !log_rdy) begin
         ovf_d = 1'b1;
      end
      // Read data and error prepared during setup
      if (setup) begin
         prdata_d = 32'h0000_0000;
         unique case (i_paddr)
            `OBT_CTRL_OFS: begin
               prdata_d[`OBT_CTRL_LOG_EN_BIT] = log_en_q;
            end
            `OBT_STATUS_OFS: begin
               prdata_d[`OBT_ST_AB_LSB +: 8] = store_q.a_to_b;
               prdata_d[`OBT_ST_BA_LSB +: 8] = store_q.b_to_a;
               prdata_d[`OBT_ST_OE_N_BIT] = ctrl.oe_n;
               prdata_d[`OBT_ST_DIR_BIT] = ctrl.dir;
               prdata_d[`OBT_ST_EMPTY_BIT] = !log_valid;
               prdata_d[`OBT_ST_FULL_BIT] = !log_rdy;
               prdata_d[`OBT_ST_OVF_BIT] = ovf_q;
            end
            `OBT_LOG_OFS: begin
               // Empty log reads as zero and pops nothing
               prdata_d[7:0] = log_valid ? log_data : 8'h00;
            end
            default: begin
               pslverr_d = 1'b1;
            end
         endcase
      end
   end

   // Register the bus-facing state
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         log_en_q <= `OBT_CTRL_RST;
         ovf_q <= 1'b0;
         lrdy_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end else begin
         log_en_q <= log_en_d;
         ovf_q <= ovf_d;
         lrdy_q <= log_rdy;
         prdata_q <= prdata_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d && pready_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs, all from flip-flops
   // ------------------------------------------------------------
   assign o_a_side_lines = a_out_q;
   assign o_a_side_oe = a_oe_q;
   assign o_b_side_lines = b_out_q;
   assign o_b_side_oe = b_oe_q;
   assign o_log_ready = lrdy_q;
   assign o_prdata = prdata_q;
   assign o_pready = pready_q;
   assign o_pslverr = pslverr_q;
endmodule

// ==== tb/obt_transceiver_asserts.sv ====
// Checker that ties the transceiver's driven lines to its controls
`timescale 1ns/1ps
module obt_chk (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Control pins
   input wire logic i_oe_n,
   input wire logic i_dir,
   input wire logic i_a_to_b_capture_clock,
   input wire logic i_b_to_a_capture_clock,
   input wire logic i_a_to_b_source_select,
   input wire logic i_b_to_a_source_select,
   // Bus lines
   input wire logic [7:0] i_a_side_lines,
   input wire logic [7:0] i_b_side_lines,
   input wire logic [7:0] o_a_side_lines,
   input wire logic o_a_side_oe,
   input wire logic [7:0] o_b_side_lines,
   input wire logic o_b_side_oe
);
   // One clock domain, so one default clock and disable for all
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);

   // ------------------------------------------------------------
   // Reference copy of both stored registers
   // ------------------------------------------------------------
   logic ab_q, ba_q; // Last capture clock levels
   logic up_q; // High once reset has been gone a full cycle
   logic [7:0] ab_m, ba_m; // Expected stored values
   logic run_b, run_a; // Enabled toward B, toward A
   assign run_b = !i_oe_n && i_dir && i_rst_n && up_q;
   assign run_a = !i_oe_n && !i_dir && i_rst_n && up_q;
   // History clears in reset, so a clock held high counts as a rise
   always_ff @(posedge i_mclk) begin
      if (!i_rst_n) begin
         {ab_q, ba_q, up_q, ab_m, ba_m} <= '0;
      end else begin
         ab_q <= i_a_to_b_capture_clock;
         ba_q <= i_b_to_a_capture_clock;
         up_q <= 1'b1;
         if (i_a_to_b_capture_clock && !ab_q) ab_m <= i_a_side_lines;
         if (i_b_to_a_capture_clock && !ba_q) ba_m <= i_b_side_lines;
      end
   end

   // ------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------
   iso_off_a: assert property ($past(i_oe_n) |->
      !o_a_side_oe && !o_b_side_oe) else $error("Driver active while off");
   drive_b_a: assert property ($past(run_b) |->
      o_b_side_oe && !o_a_side_oe) else $error("B side not driven");
   drive_a_a: assert property ($past(run_a) |->
      o_a_side_oe && !o_b_side_oe) else $error("A side not driven");
   live_b_a: assert property ($past(run_b && !i_a_to_b_source_select)
      |-> o_b_side_lines == $past(i_a_side_lines))
      else $error("B side does not follow A");
   kept_b_a: assert property ($past(run_b && i_a_to_b_source_select)
      |-> o_b_side_lines == ab_m) else $error("B side not stored value");
   live_a_a: assert property ($past(run_a && !i_b_to_a_source_select)
      |-> o_a_side_lines == $past(i_b_side_lines))
      else $error("A side does not follow B");
   kept_a_a: assert property ($past(run_a && i_b_to_a_source_select)
      |-> o_a_side_lines == ba_m) else $error("A side not stored value");
   hold_b_a: assert property ((run_b && i_a_to_b_source_select &&
      !i_a_to_b_capture_clock)[*2] |=> $stable(o_b_side_lines))
      else $error("Stored value moved without a capture");
endmodule

bind obt_transceiver obt_chk chk_u (
   .i_mclk(i_mclk),
   .i_rst_n(i_rst_n),
   .i_oe_n(i_oe_n),
   .i_dir(i_dir),
   .i_a_to_b_capture_clock(i_a_to_b_capture_clock),
   .i_b_to_a_capture_clock(i_b_to_a_capture_clock),
   .i_a_to_b_source_select(i_a_to_b_source_select),
   .i_b_to_a_source_select(i_b_to_a_source_select),
   .i_a_side_lines(i_a_side_lines),
   .i_b_side_lines(i_b_side_lines),
   .o_a_side_lines(o_a_side_lines),
   .o_a_side_oe(o_a_side_oe),
   .o_b_side_lines(o_b_side_lines),
   .o_b_side_oe(o_b_side_oe)
);

// ==== tb/obt_bus_agent.sv ====
// Far-side logic that drives the A or B lines of the transceiver
`timescale 1ns/1ps
module obt_bus_agent (
   // Clock
   input wire logic i_mclk,
   // Device drive state
   input wire logic i_a_oe,
   input wire logic i_b_oe,
   input wire logic [7:0] i_a_dev,
   input wire logic [7:0] i_b_dev,
   // Bench requests
   input wire logic i_want_a,
   input wire logic i_want_b,
   input wire logic [7:0] i_a_val,
   input wire logic [7:0] i_b_val,
   // Resolved bus levels
   output logic [7:0] o_a_bus,
   output logic [7:0] o_b_bus
);
   logic [7:0] idle_q = 8'h55; // Floating lines wander every cycle
   logic drv_a, drv_b;
   // One bus at a time, never the side the device drives
   assign drv_a = i_want_a && !i_a_oe;
   assign drv_b = i_want_b && !i_want_a && !i_b_oe;
   // A stale value on a released bus would hide a missed capture
   always_ff @(posedge i_mclk) begin
      idle_q <= ~idle_q;
   end
   assign o_a_bus = i_a_oe ? i_a_dev : (drv_a ? i_a_val : idle_q);
   assign o_b_bus = i_b_oe ? i_b_dev : (drv_b ? i_b_val : idle_q);
endmodule

// ==== tb/tb.sv ====
// Self-checking bench for the octal registered bus transceiver
`timescale 1ns/1ps
`include "obt_defines.svh"
`define CHK(g, x) \
   begin \
      check_count++; \
      if ((g) !== (x)) begin \
         mismatches++; \
         $display("BAD t=%0t got=%h exp=%h", $time, (g), (x)); \
      end \
   end
module tb;
   // ------------------------------------------------------------
   // Stimulus and observed signals
   // ------------------------------------------------------------
   logic clk = 1'b0, rst_n = 1'b0, oe_n = 1'b1, dir = 1'b0;
   logic ab_clk = 1'b0, ba_clk = 1'b0, ab_sel = 1'b0, ba_sel = 1'b0;
   logic want_a = 1'b0, want_b = 1'b0; // Far-side requests
   logic [7:0] va = 8'h00, vb = 8'h00; // Far-side values
   logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
   logic [11:0] padr = 12'h000;
   logic [31:0] pwd = 32'h0, prd, r;
   logic rdy, pslv, a_oe, b_oe, lrdy, e;
   logic [7:0] a_bus, b_bus, a_out, b_out;
   logic [7:0] vals [3] = '{8'h00, 8'hff, 8'h96}; // Edge patterns
   int mismatches = 0, check_count = 0;

   initial begin
      forever #2 clk = ~clk;
   end

   obt_transceiver dut_u (.i_mclk(clk), .i_rst_n(rst_n), .i_oe_n(oe_n),
      .i_dir(dir), .i_a_to_b_capture_clock(ab_clk),
      .i_b_to_a_capture_clock(ba_clk), .i_a_to_b_source_select(ab_sel),
      .i_b_to_a_source_select(ba_sel), .i_a_side_lines(a_bus),
      .o_a_side_lines(a_out), .o_a_side_oe(a_oe), .i_b_side_lines(b_bus),
      .o_b_side_lines(b_out), .o_b_side_oe(b_oe), .o_log_ready(lrdy),
      .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr),
      .i_pwdata(pwd), .o_prdata(prd), .o_pready(rdy), .o_pslverr(pslv));
   obt_bus_agent agent_u (.i_mclk(clk), .i_a_oe(a_oe), .i_b_oe(b_oe),
      .i_a_dev(a_out), .i_b_dev(b_out), .i_want_a(want_a),
      .i_want_b(want_b), .i_a_val(va), .i_b_val(vb), .o_a_bus(a_bus),
      .o_b_bus(b_bus));

   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic results;
      $display("Checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic st; // Let outputs settle
      repeat (3) @(posedge clk);
      #1;
   endtask
   // One APB transfer; read data lands in r, error in e
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      {psel, pen, pwr, padr, pwd} <= {2'b10, w, ad, wd};
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      r = prd;
      e = pslv;
      {psel, pen} <= 2'b00;
      if (rdy !== 1'b1) begin
         mismatches++;
         results();
      end
   endtask
   task automatic drv(input logic sa, input logic [7:0] v);
      @(posedge clk);
      {want_a, want_b, va, vb} <= {sa, !sa, v, v};
   endtask
   task automatic cap(input logic ab); // One capture clock rise
      @(posedge clk);
      {ab_clk, ba_clk} <= {ab, !ab};
      @(posedge clk);
      {ab_clk, ba_clk} <= 2'b00;
   endtask
   task automatic mode(input logic [3:0] m);
      @(posedge clk);
      {oe_n, dir, ab_sel, ba_sel} <= m;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic s_iso; // Both buses inputs, both registers load
      st();
      apb(1'b0, `OBT_STATUS_OFS, 32'h0);
      `CHK(r[15:0], 16'h0000)
      drv(1'b1, 8'ha5);
      cap(1'b1);
      drv(1'b0, 8'h3c);
      cap(1'b0);
      st();
      `CHK({a_oe, b_oe}, 2'b00)
      apb(1'b0, `OBT_STATUS_OFS, 32'h0);
      `CHK(r[17:0], 18'h13ca5)
   endtask
   task automatic s_live; // Transparent paths both ways
      mode(4'b0100);
      foreach (vals[i]) begin
         drv(1'b1, vals[i]);
         st();
         `CHK(b_bus, vals[i])
      end
      `CHK({a_oe, b_oe}, 2'b01)
      drv(1'b0, 8'h00);
      mode(4'b0000);
      foreach (vals[i]) begin
         drv(1'b0, vals[i]);
         st();
         `CHK(a_bus, vals[i])
      end
      `CHK({a_oe, b_oe}, 2'b10)
   endtask
   task automatic s_store; // Stored data, new captures, hold
      drv(1'b1, 8'h77);
      mode(4'b0110);
      st();
      `CHK(b_bus, 8'ha5)
      cap(1'b1);
      st();
      `CHK(b_bus, 8'h77)
      drv(1'b1, 8'h11);
      st();
      `CHK(b_bus, 8'h77)
      cap(1'b0);
      apb(1'b0, `OBT_STATUS_OFS, 32'h0);
      `CHK(r[15:0], 16'h7777)
      drv(1'b0, 8'h42);
      mode(4'b0001);
      st();
      `CHK(a_bus, 8'h77)
      cap(1'b0);
      st();
      `CHK(a_bus, 8'h42)
   endtask
   task automatic s_log; // Register access, log fill and drain
      apb(1'b1, `OBT_CTRL_OFS, 32'h1);
      apb(1'b0, `OBT_CTRL_OFS, 32'h0);
      `CHK(r, 32'h1)
      apb(1'b0, 12'h0ff, 32'h0);
      `CHK({e, r}, 33'h100000000)
      mode(4'b1100);
      for (int i = 1; i <= 5; i++) begin
         drv(1'b1, 8'(i));
         cap(1'b1);
      end
      st();
      `CHK(lrdy, 1'b0)
      apb(1'b0, `OBT_STATUS_OFS, 32'h0);
      `CHK(r[20:18], 3'b110)
      for (int i = 1; i <= 4; i++) begin
         apb(1'b0, `OBT_LOG_OFS, 32'h0);
         `CHK(r[7:0], 8'(i))
      end
      apb(1'b1, `OBT_STATUS_OFS, 32'h100000);
      apb(1'b0, `OBT_STATUS_OFS, 32'h0);
      `CHK(r[20:18], 3'b001)
   endtask

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      s_iso();
      s_live();
      s_store();
      s_log();
      results();
   end
endmodule
